// File: tb.sv
// self-checking bench for the transceiver control sequencer
`timescale 1ns/1ps
module tb;
	import tcs_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, slow = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic emerg_call_n = 1'b1, tune_sel_n = 1'b1, mute_on_n = 1'b1, sideband_usb = 1'b0;
	logic [7:0] supply_adc = 8'h78, forward_power_sense = 8'h64, reflected_power_sense = 8'h0a;
	logic [3:0] chan_sw = 4'h0, clar_sw = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exp_rd_req, exp_rd_ack;
	logic synth_valid, synth_ready, outx_valid, outx_ready, pa_valid, pa_ready;
	logic tone_out_a, tone_out_b, lo_usb_sel, carrier_gate_en, ctl_run;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic [7:0] exp_rd_data, pa_word;
	logic [15:0] coarse_synth, fine_synth, outx_word;
	int mismatches = 0, samples_checked = 0, cycles = 0, i, k, ha, hb;

	tcs_top #(.TONE_A_HALF(4), .TONE_B_HALF(3), .BEEP_CYC(20), .POLL_CYC(16)) uut (.clk, .rst_n, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .emerg_call_n,
		.tune_sel_n, .mute_on_n, .sideband_usb, .supply_adc, .forward_power_sense, .reflected_power_sense,
		.exp_rd_req, .exp_rd_ack, .exp_rd_data, .synth_valid, .synth_ready, .coarse_synth, .fine_synth,
		.outx_valid, .outx_ready, .outx_word, .pa_valid, .pa_ready, .pa_word, .tone_out_a, .tone_out_b,
		.lo_usb_sel, .carrier_gate_en, .ctl_run);
	tcs_far_model far (.clk, .rst_n, .slow, .req({exp_rd_req, synth_valid, outx_valid, pa_valid}),
		.ack({exp_rd_ack, synth_ready, outx_ready, pa_ready}), .sw({chan_sw, clar_sw}), .exp_rd_data);

	always #10 clk = ~clk;

	function automatic logic [3:0] gray(input int p);
		return 4'(p ^ (p >> 1));
	endfunction
	task automatic complete_run();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic t;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk) t = s_axi_awready & s_axi_wready;
			@(posedge clk);
		end while (!t);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do begin
			@(negedge clk) t = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk);
		end while (!t);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		logic t;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk) t = s_axi_arready;
			@(posedge clk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge clk) t = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
		end while (!t);
		s_axi_rready <= 1'b0;
	endtask
	task automatic poll_stat(input logic [31:0] m, input logic [31:0] v, input string what);
		axi_rd(A_STAT);
		for (int n = 0; n < 60 && (rd & m) !== v; n++) axi_rd(A_STAT);
		check(rd & m, v, what);
	endtask
	task automatic tone_toggles(output int a, output int b);
		logic qa, qb;
		a = 0;
		b = 0;
		@(negedge clk);
		for (int j = 0; j < 48; j++) begin
			qa = tone_out_a;
			qb = tone_out_b;
			@(negedge clk);
			a += (tone_out_a !== qa);
			b += (tone_out_b !== qb);
		end
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			$display("BAD %0t run timed out", $time);
			complete_run();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 100 && ctl_run !== 1'b1; i++) @(posedge clk);
		check(ctl_run, 1'b1, "run after reset");
		axi_rd(A_CTRL);
		check(rd, 32'h0000_0000, "ctrl reset value");
		axi_wr(A_CTRL, 32'h0000_0001);
		axi_rd(A_CTRL);
		check(rd, 32'h0000_0001, "ctrl readback");
		for (i = 0; i < 300 && outx_word[8] !== 1'b1; i++) @(posedge clk);
		check(outx_word[8], 1'b1, "unlock line");
		axi_wr(8'h80, 32'h0000_0001);
		check(rsp, RESP_SLV, "unmapped write");
		axi_rd(8'h80);
		check(rd, 32'h0000_0000, "unmapped read data");
		check(rsp, RESP_SLV, "unmapped read");
		axi_wr(8'h44, 32'h0003_09c4);
		axi_wr(8'h48, 32'h0004_1f40);
		chan_sw <= gray(2);
		poll_stat(32'h0000_001f, 32'h0000_0012, "channel two");
		for (i = 0; i < 300 && coarse_synth !== 16'h0fa0; i++) @(posedge clk);
		check(coarse_synth, 16'h0fa0, "coarse word");
		for (i = 0; i < 300 && (pa_word[5] !== 1'b1 || lo_usb_sel !== 1'b1); i++) @(posedge clk);
		check(pa_word[5], 1'b1, "antenna two");
		check($countones(~pa_word[4:0]), 1, "one filter");
		check(lo_usb_sel, 1'b1, "sideband locked");
		chan_sw <= gray(10);
		repeat (100) @(posedge clk);
		poll_stat(32'h0000_000f, 32'h0000_0002, "unused position");
		chan_sw <= gray(1);
		poll_stat(32'h0000_001f, 32'h0000_0011, "channel one");
		for (i = 0; i < 300 && (pa_word[5] !== 1'b0 || lo_usb_sel !== 1'b0); i++) @(posedge clk);
		check(pa_word[5], 1'b0, "antenna one");
		check(lo_usb_sel, 1'b0, "lower sideband");
		slow <= 1'b1;
		for (k = 1; k < 7; k++) begin
			clar_sw <= gray(k);
			repeat (120) @(posedge clk);
			axi_rd(A_STAT);
			check(rd[23:16], (k < 5) ? k : 5, "clarifier steps");
		end
		clar_sw <= gray(5);
		for (i = 0; i < 300 && fine_synth !== FINE_CTR + 16'h0004; i++) @(posedge clk);
		check(fine_synth, FINE_CTR + 16'h0004, "clarifier step down");
		axi_rd(A_STAT);
		check(rd[23:16], 8'h04, "clarifier count down");
		chan_sw <= gray(2);
		poll_stat(32'h00ff_0000, 32'h0000_0000, "clarifier centred");
		chan_sw <= gray(1);
		poll_stat(32'h0000_001f, 32'h0000_0011, "back to one");
		tune_sel_n <= 1'b0;
		for (i = 0; i < 300 && (outx_word[2] !== 1'b0 || pa_word[6] !== 1'b0); i++) @(posedge clk);
		check({outx_word[12], outx_word[2], outx_word[0]}, 3'b100, "tune keys and injects");
		check(carrier_gate_en, 1'b1, "carrier gate");
		check(pa_word[6], 1'b0, "relay to transmit");
		clar_sw <= gray(6);
		repeat (120) @(posedge clk);
		axi_rd(A_STAT);
		check(rd[23:16], 8'h00, "clarifier held in transmit");
		tune_sel_n <= 1'b1;
		poll_stat(32'h0000_0600, 32'h0000_0200, "tune pass");
		for (i = 0; i < 300 && carrier_gate_en !== 1'b0; i++) @(posedge clk);
		check(carrier_gate_en, 1'b0, "carrier gate closed");
		reflected_power_sense <= 8'h32;
		tune_sel_n <= 1'b0;
		repeat (100) @(posedge clk);
		tune_sel_n <= 1'b1;
		poll_stat(32'h0000_0600, 32'h0000_0400, "tune fail");
		mute_on_n <= 1'b0;
		for (i = 0; i < 300 && outx_word[3] !== 1'b1; i++) @(posedge clk);
		check(outx_word[3], 1'b1, "mute output");
		emerg_call_n <= 1'b0;
		for (i = 0; i < 300 && outx_word[0] !== 1'b0; i++) @(posedge clk);
		check(outx_word[0], 1'b0, "emergency keying");
		tone_toggles(ha, hb);
		check(ha >= 11 && ha <= 13 && hb >= 15 && hb <= 17, 1, "two emergency tones");
		emerg_call_n <= 1'b1;
		supply_adc <= 8'ha6;
		poll_stat(32'h0000_0080, 32'h0000_0080, "over voltage");
		tone_toggles(ha, hb);
		check(ha == 0 && hb >= 15 && hb <= 17, 1, "high alarm tone");
		tune_sel_n <= 1'b0;
		repeat (100) @(posedge clk);
		check(outx_word[0], 1'b1, "keying disabled");
		tune_sel_n <= 1'b1;
		repeat (10) @(posedge clk);
		supply_adc <= 8'h64;
		poll_stat(32'h0000_01c0, 32'h0000_0140, "low voltage");
		tone_toggles(ha, hb);
		check(ha >= 11 && ha <= 13 && hb == 0, 1, "low warning tone");
		supply_adc <= 8'h56;
		for (i = 0; i < 100 && ctl_run !== 1'b0; i++) @(posedge clk);
		check(ctl_run, 1'b0, "held in reset");
		supply_adc <= 8'h59;
		repeat (50) @(posedge clk);
		check(ctl_run, 1'b0, "hysteresis");
		supply_adc <= 8'h5b;
		for (i = 0; i < 100 && ctl_run !== 1'b1; i++) @(posedge clk);
		check(ctl_run, 1'b1, "released");
		ce <= 1'b0;
		tone_toggles(ha, hb);
		check(ha, 0, "frozen by clock enable");
		ce <= 1'b1;
		tone_toggles(ha, hb);
		check(ha >= 11 && ha <= 13, 1, "running after enable");
		complete_run();
	end
endmodule // tb

// File: tcs_far_model.sv
// far side model: switch expander, synthesizers, output and PA expanders
`timescale 1ns/1ps
module tcs_far_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [3:0] req,
	output logic [3:0] ack,
	input wire logic [7:0] sw,
	output logic [7:0] exp_rd_data
);
	logic [2:0] wait_r [4];
	// each unit answers a held request at once or after five idle cycles
	always_ff @(posedge clk or negedge rst_n) begin
		for (int k = 0; k < 4; k++) begin
			if (!rst_n) begin
				ack[k] <= 1'b0;
				wait_r[k] <= 3'h0;
			end else if (req[k] && !ack[k] && (!slow || wait_r[k] == 3'h5)) begin
				ack[k] <= 1'b1;
				wait_r[k] <= 3'h0;
			end else begin
				ack[k] <= 1'b0;
				wait_r[k] <= (req[k] && !ack[k]) ? wait_r[k] + 3'h1 : 3'h0;
			end
		end
	end
	// switch lines valid only with ack, otherwise the bus shows the inverse
	assign exp_rd_data = ack[3] ? sw : ~sw;
endmodule // tcs_far_model

// File: tcs_pkg.sv
// constants, field positions and addresses of the transceiver control sequencer
package tcs_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int TONE_A_HZ = 880;
	localparam int TONE_B_HZ = 1320;
	localparam int TONE_A_HALF = CLK_HZ / (2 * TONE_A_HZ);
	localparam int TONE_B_HALF = CLK_HZ / (2 * TONE_B_HZ);
	localparam int BEEP_MS = 200;
	localparam int BEEP_CYC = CLK_HZ / 1000 * BEEP_MS;
	localparam int POLL_US = 1000;
	localparam int POLL_CYC = CLK_HZ / 1_000_000 * POLL_US;
	localparam int CLAR_STEP_HZ = 10;
	localparam int CLAR_LO_HZ = 50;
	localparam int CLAR_PPM = 10;
	localparam logic [15:0] CLAR_HI_KHZ = 16'h1388;
	localparam logic [3:0] CH_POS = 4'hc;
	localparam logic [3:0] CH_VALID = 4'ha;
	localparam logic [7:0] SUP_HI = 8'ha5;
	localparam logic [7:0] SUP_LO = 8'h69;
	localparam logic [7:0] SUP_RST_LO = 8'h57;
	localparam logic [7:0] SUP_RST_HI = 8'h5a;
	localparam int VSWR_SHIFT = 2;
	localparam logic [15:0] FLT_K1 = 16'h0bb8;
	localparam logic [15:0] FLT_K2 = 16'h1388;
	localparam logic [15:0] FLT_K3 = 16'h1f40;
	localparam logic [15:0] FLT_K4 = 16'h2ee0;
	localparam logic [15:0] FINE_CTR = 16'h1000;
	localparam int TB_EMG = 16;
	localparam int TB_SBE = 17;
	localparam int TB_ANT = 18;
	localparam int OX_KEY = 0;
	localparam int OX_USB = 1;
	localparam int OX_INJ = 2;
	localparam int OX_MUTE = 3;
	localparam int OX_ISO = 12;
	localparam int PA_ANT = 5;
	localparam int PA_TR = 6;
	localparam int CT_UNL1 = 0;
	localparam int CT_UNL2 = 1;
	localparam int CT_CLAMP = 2;
	localparam int CT_MIC = 3;
	localparam int CT_BCD = 4;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_ADC = 8'h08;
	localparam logic [1:0] A_TBL_HI = 2'h1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLV = 2'h2;
	localparam logic [1:0] BK_PASS = 2'h1;
	localparam logic [1:0] BK_FAIL = 2'h2;
	localparam logic [1:0] BK_LIM = 2'h3;
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_SYN, ST_OUT, ST_PA} tcs_st_t;
endpackage

// File: tcs_top.sv
// transceiver control sequencer with its register slave
`timescale 1ns/1ps
module tcs_top #(
	parameter int TONE_A_HALF = tcs_pkg::TONE_A_HALF,
	parameter int TONE_B_HALF = tcs_pkg::TONE_B_HALF,
	parameter int BEEP_CYC = tcs_pkg::BEEP_CYC,
	parameter int POLL_CYC = tcs_pkg::POLL_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic emerg_call_n,
	input wire logic tune_sel_n,
	input wire logic mute_on_n,
	input wire logic sideband_usb,
	input wire logic [7:0] supply_adc,
	input wire logic [7:0] forward_power_sense,
	input wire logic [7:0] reflected_power_sense,
	output logic exp_rd_req,
	input wire logic exp_rd_ack,
	input wire logic [7:0] exp_rd_data,
	output logic synth_valid,
	input wire logic synth_ready,
	output logic [15:0] coarse_synth,
	output logic [15:0] fine_synth,
	output logic outx_valid,
	input wire logic outx_ready,
	output logic [15:0] outx_word,
	output logic pa_valid,
	input wire logic pa_ready,
	output logic [7:0] pa_word,
	output logic tone_out_a,
	output logic tone_out_b,
	output logic lo_usb_sel,
	output logic carrier_gate_en,
	output logic ctl_run
);
	import tcs_pkg::*;

	typedef struct packed {
		tcs_st_t st;
		logic [3:0] ps1;
		logic [3:0] ps2;
		logic [9:0][31:0] tbl;
		logic [31:0] ctrl;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic sup_ok;
		logic ovv;
		logic lowv;
		logic seeded;
		logic [3:0] chan;
		logic chan_ok;
		logic [3:0] cgr;
		logic [3:0] kgr;
		logic signed [7:0] clar;
		logic [31:0] poll;
		logic [31:0] beep;
		logic [1:0] bk;
		logic [31:0] ta;
		logic [31:0] tb;
		logic pha;
		logic phb;
		logic tone_a;
		logic tone_b;
		logic tx;
		logic tune_was;
		logic pass;
		logic fail;
		logic [15:0] syn_c;
		logic [15:0] syn_f;
		logic [15:0] ox;
		logic [7:0] pa;
	} tcs_s_t;

	tcs_s_t r;
	tcs_s_t n;
	logic tune, emg, emg_ok, en_op, tx_n, usb, inject, vswr_ok, wr, rd, ta_en, tb_en;
	logic [31:0] ent;
	logic [15:0] freq, ox_new, syn_c_new, syn_f_new;
	logic [7:0] pa_new, lim;
	logic [4:0] flt_n;
	logic [3:0] cb, kb, kp;

	function automatic logic [3:0] g2b(input logic [3:0] g);
		logic [3:0] b;
		b[3] = g[3];
		for (int i = 2; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction

	function automatic logic [3:0] inc12(input logic [3:0] x);
		return (x == CH_POS - 4'h1) ? 4'h0 : x + 4'h1;
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] v;
		v = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				v[i * 8 +: 8] = d[i * 8 +: 8];
			end
		end
		return v;
	endfunction

	assign tune = r.ps2[1];
	assign emg = r.ps2[0];
	assign ent = r.tbl[r.chan];
	assign freq = ent[15:0];
	assign en_op = r.sup_ok && !r.ovv;
	assign emg_ok = emg && ent[TB_EMG] && r.chan_ok;
	assign tx_n = en_op && (tune || emg_ok);
	assign inject = tune && tx_n;
	assign usb = ent[TB_SBE] ? r.ps2[3] : 1'b1;
	assign vswr_ok = {reflected_power_sense, 2'(0)} < {2'(0), forward_power_sense};
	assign lim = (freq < CLAR_HI_KHZ) ? 8'(CLAR_LO_HZ / CLAR_STEP_HZ) :
		8'((32'(freq) * CLAR_PPM) / (1000 * CLAR_STEP_HZ));
	assign syn_c_new = {1'b0, freq[15:1]};
	assign syn_f_new = FINE_CTR + {{8{r.clar[7]}}, r.clar};
	assign flt_n = (freq < FLT_K1) ? 5'b11110 : (freq < FLT_K2) ? 5'b11101 :
		(freq < FLT_K3) ? 5'b11011 : (freq < FLT_K4) ? 5'b10111 : 5'b01111;
	assign pa_new = {1'b1, ~r.tx, ent[TB_ANT], flt_n};
	assign ox_new = {3'b000, inject, emg_ok, r.ctrl[CT_MIC], r.ctrl[CT_UNL2], r.ctrl[CT_UNL1],
		r.ctrl[CT_BCD +: 3], r.ctrl[CT_CLAMP], r.ps2[2], ~inject, usb, ~tx_n};
	assign cb = g2b(exp_rd_data[7:4]);
	assign kb = g2b(exp_rd_data[3:0]);
	assign kp = g2b(r.kgr);
	assign ta_en = (emg_ok && r.tx) || r.lowv || (r.beep != 0 && r.bk == BK_FAIL);
	assign tb_en = (emg_ok && r.tx) || r.ovv || (r.beep != 0 && r.bk != BK_FAIL);
	assign wr = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
	assign rd = s_axi_arvalid && !r.rvalid;

	always_comb begin
		n = r;
		n.ps1 = {sideband_usb, ~mute_on_n, ~tune_sel_n, ~emerg_call_n};
		n.ps2 = r.ps1;
		if (supply_adc < SUP_RST_LO) begin
			n.sup_ok = 1'b0;
		end else if (supply_adc > SUP_RST_HI) begin
			n.sup_ok = 1'b1;
		end
		n.ovv = supply_adc > SUP_HI;
		n.lowv = supply_adc < SUP_LO;
		n.tx = tx_n;
		n.tune_was = inject;
		if (r.ta >= 32'(TONE_A_HALF - 1)) begin
			n.ta = '0;
			n.pha = ~r.pha;
		end else begin
			n.ta = r.ta + 32'h0000_0001;
		end
		if (r.tb >= 32'(TONE_B_HALF - 1)) begin
			n.tb = '0;
			n.phb = ~r.phb;
		end else begin
			n.tb = r.tb + 32'h0000_0001;
		end
		n.tone_a = ta_en && r.pha;
		n.tone_b = tb_en && r.phb;
		if (r.beep != 0) begin
			n.beep = r.beep - 32'h0000_0001;
		end
		if (r.tune_was && !tune) begin
			n.pass = vswr_ok;
			n.fail = !vswr_ok;
			n.bk = vswr_ok ? BK_PASS : BK_FAIL;
			n.beep = 32'(BEEP_CYC - 1);
		end
		unique case (r.st)
			ST_IDLE: begin
				if (!r.sup_ok) begin
					n.poll = '0;
				end else if (syn_c_new != r.syn_c || syn_f_new != r.syn_f) begin
					n.syn_c = syn_c_new;
					n.syn_f = syn_f_new;
					n.st = ST_SYN;
				end else if (pa_new != r.pa) begin
					n.pa = pa_new;
					n.st = ST_PA;
				end else if (ox_new != r.ox) begin
					n.ox = ox_new;
					n.st = ST_OUT;
				end else if (r.poll >= 32'(POLL_CYC - 1)) begin
					n.poll = '0;
					n.st = ST_RD;
				end else begin
					n.poll = r.poll + 32'h0000_0001;
				end
			end
			ST_RD: begin
				if (exp_rd_ack) begin
					n.st = ST_IDLE;
					n.seeded = 1'b1;
					n.cgr = exp_rd_data[7:4];
					n.kgr = exp_rd_data[3:0];
					if (cb < CH_VALID && (!r.seeded || cb != r.chan || !r.chan_ok)) begin
						n.chan = cb;
						n.chan_ok = 1'b1;
						n.clar = '0;
					end else if (r.seeded && !r.tx && $onehot(exp_rd_data[3:0] ^ r.kgr)
						&& kb < CH_POS && kp < CH_POS) begin
						if (kb == inc12(kp)) begin
							if (r.clar < $signed(lim)) begin
								n.clar = r.clar + 8'sh01;
							end else begin
								n.bk = BK_LIM;
								n.beep = 32'(BEEP_CYC - 1);
							end
						end else if (kp == inc12(kb)) begin
							if (r.clar > -$signed(lim)) begin
								n.clar = r.clar - 8'sh01;
							end else begin
								n.bk = BK_LIM;
								n.beep = 32'(BEEP_CYC - 1);
							end
						end
					end
				end
			end
			ST_SYN: begin
				if (synth_ready) begin
					n.st = ST_IDLE;
				end
			end
			ST_OUT: begin
				if (outx_ready) begin
					n.st = ST_IDLE;
				end
			end
			ST_PA: begin
				if (pa_ready) begin
					n.st = ST_IDLE;
				end
			end
		endcase
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (wr) begin
			n.bvalid = 1'b1;
			n.bresp = RESP_OK;
			if (s_axi_awaddr[7:2] == A_CTRL[7:2]) begin
				n.ctrl = wmerge(r.ctrl, s_axi_wdata, s_axi_wstrb);
			end else if (s_axi_awaddr[7:6] == A_TBL_HI && s_axi_awaddr[5:2] < CH_VALID) begin
				n.tbl[s_axi_awaddr[5:2]] = wmerge(r.tbl[s_axi_awaddr[5:2]], s_axi_wdata, s_axi_wstrb);
			end else if (s_axi_awaddr[7:2] != A_STAT[7:2] && s_axi_awaddr[7:2] != A_ADC[7:2]) begin
				n.bresp = RESP_SLV;
			end
		end
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (rd) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OK;
			n.rdata = '0;
			if (s_axi_araddr[7:2] == A_CTRL[7:2]) begin
				n.rdata = r.ctrl;
			end else if (s_axi_araddr[7:2] == A_STAT[7:2]) begin
				n.rdata = {8'h00, r.clar, 4'h0, usb, r.fail, r.pass, r.lowv, r.ovv, r.sup_ok, r.tx,
					r.chan_ok, r.chan};
			end else if (s_axi_araddr[7:2] == A_ADC[7:2]) begin
				n.rdata = {8'h00, reflected_power_sense, forward_power_sense, supply_adc};
			end else if (s_axi_araddr[7:6] == A_TBL_HI && s_axi_araddr[5:2] < CH_VALID) begin
				n.rdata = r.tbl[s_axi_araddr[5:2]];
			end else begin
				n.rresp = RESP_SLV;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign s_axi_awready = wr && ce;
	assign s_axi_wready = wr && ce;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = rd && ce;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign exp_rd_req = r.st == ST_RD;
	assign synth_valid = r.st == ST_SYN;
	assign outx_valid = r.st == ST_OUT;
	assign pa_valid = r.st == ST_PA;
	assign coarse_synth = r.syn_c;
	assign fine_synth = r.syn_f;
	assign outx_word = r.ox;
	assign pa_word = r.pa;
	assign tone_out_a = r.tone_a;
	assign tone_out_b = r.tone_b;
	assign lo_usb_sel = r.ox[OX_USB];
	assign carrier_gate_en = !r.ox[OX_INJ];
	assign ctl_run = r.sup_ok;

	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (!rst_n || !ce);

	chk_chan_range: assert property (r.chan < CH_VALID)
		else $error("channel index out of range");
	chk_chan_synth: assert property (r.sup_ok && $changed(r.chan) |-> ##[0:8] synth_valid)
		else $error("no synth update after channel change");
	chk_clar_rx: assert property (r.tx ##1 $stable(r.chan) |-> $stable(r.clar))
		else $error("clarifier moved in transmit");
	chk_clar_lim: assert property ((r.clar >= 0) ? (r.clar <= $signed(lim)) : (-r.clar <= $signed(lim)))
		else $error("clarifier beyond limit");
	chk_clar_ctr: assert property ($changed(r.chan) |-> r.clar == 0)
		else $error("clarifier not centred on channel change");
	chk_tune_key: assert property (tune && en_op |-> ##[1:40]
		(!outx_word[OX_KEY] && !outx_word[OX_INJ] && outx_word[OX_ISO]))
		else $error("tune did not key and inject");
	chk_ovv_off: assert property (r.ovv |=> !r.tx)
		else $error("transmit while over voltage");
	chk_pa_onehot: assert property (pa_valid |-> $countones(pa_word[4:0]) == 4)
		else $error("filter select not one-hot low");
	chk_tr_relay: assert property ($rose(r.tx) && r.st == ST_IDLE |-> ##[1:2] (pa_valid && !pa_word[PA_TR]))
		else $error("relay not sent on keying");
	chk_sup_reset: assert property (supply_adc < SUP_RST_LO |=> !ctl_run)
		else $error("run while supply low");

	cov_chan_change: cover property ($changed(r.chan));
	cov_tune_pass: cover property ($rose(r.pass));
	cov_emerg_tx: cover property (emg_ok && r.tx);
	cov_clar_limit: cover property (r.bk == BK_LIM && r.beep != 0);
endmodule // tcs_top
